// ===== hdl/bdc_top.sv
/*
 * bdc_top: digital control of a 5-bit bias dac. Pin style: saturating
 * up/down counter from raise and lower edges. Serial style: bus target
 * writing config banks and dac code. Panel switch and dac output gating.
 * Assumes: all pins asynchronous; the host frames each serial
 * transaction with a start pulse on i_link_start, then gives two more
 * link clocks before the address, since the start pin is synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
module bdc_top (
	// system
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic       i_supply_low_lockout,
	// variant select: high = serial style
	input  wire logic       i_serial_mode,
	// pin-style controls
	input  wire logic       i_raise_magnitude_in,
	input  wire logic       i_lower_magnitude_in,
	input  wire logic       i_power_down_n,
	input  wire logic       i_output_sign_select,
	input  wire logic       i_supply_good_sense,
	input  wire logic       i_standby_select_n,
	// serial link
	input  wire logic       i_scl,
	input  wire logic       i_link_start,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	// outputs
	output logic            o_panel_switch_drive,
	output logic            o_panel_switch_drive_oe,
	output logic [4:0]      o_dac_code_bits,
	output logic            o_shutdown
);
	import bdc_pkg::*;

	bdc_wr_if wr ();

	logic [4:0] dac_reg;
	logic [4:0] dac_next;
	logic [1:0] standby_config_reg;
	logic [1:0] operate_config_reg;
	logic       raise_s;
	logic       lower_s;
	logic       pdn_n_s;
	logic       sign_s;
	logic       good_s;
	logic       stby_n_s;
	logic       supply_low_lockout_s;
	logic       tog_s;
	logic       raise_d_reg;
	logic       lower_d_reg;
	logic       tog_d_reg;
	logic       wr_seen;
	logic       raise_rise;
	logic       lower_rise;
	logic       shutdown;
	logic [1:0] active_config;
	logic       panel_on;
	logic       link_rst_s;
	logic [7:0] status_reg;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	bdc_sync #(.WIDTH(8)) u_pin_sync (
		.i_clk   (i_sys_clk),
		.i_rst   (i_rst),
		.i_async ({i_raise_magnitude_in, i_lower_magnitude_in, i_power_down_n,
			i_output_sign_select, i_supply_good_sense, i_standby_select_n,
			i_supply_low_lockout, wr.wr_toggle}),
		.o_sync  ({raise_s, lower_s, pdn_n_s, sign_s, good_s, stby_n_s,
			supply_low_lockout_s, tog_s})
	);

	// link reset: start pulse, or system reset, taken to the link domain
	bdc_sync #(.WIDTH(1)) u_link_rst_sync (
		.i_clk   (i_scl),
		.i_rst   (1'b0),
		.i_async (i_rst | i_link_start),
		.o_sync  (link_rst_s)
	);

	bdc_serial_target u_target (
		.i_scl      (i_scl),
		.i_rst_link (link_rst_s),
		.i_sda      (i_sda),
		.o_sda_oe   (o_sda_oe),
		.wr         (wr.link)
	);

	// open drain: only ever drives low
	assign o_sda = 1'b0;

	// ----------------------------------------------------------------
	// edge detect and write flag in system domain
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			raise_d_reg <= 1'b0;
			lower_d_reg <= 1'b0;
			tog_d_reg   <= 1'b0;
		end
		else
		begin
			raise_d_reg <= raise_s;
			lower_d_reg <= lower_s;
			tog_d_reg   <= tog_s;
		end
	end

	assign raise_rise = raise_s & ~raise_d_reg;
	assign lower_rise = lower_s & ~lower_d_reg;
	// the fall at the next frame's start must not count as a write
	assign wr_seen    = tog_s & ~tog_d_reg;

	// ----------------------------------------------------------------
	// active configuration and shutdown
	// ----------------------------------------------------------------
	assign active_config = stby_n_s ? operate_config_reg : standby_config_reg;
	always_comb
	begin
		if (i_serial_mode)
			shutdown = ~active_config[1];
		else
			shutdown = ~pdn_n_s;
	end
	assign panel_on = i_serial_mode ? active_config[0] : 1'b1;

	// ----------------------------------------------------------------
	// configuration banks, written from serial bytes
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || supply_low_lockout_s)
		begin
			standby_config_reg <= STANDBY_RESET;
			operate_config_reg <= OPERATE_RESET;
		end
		else if (wr_seen && i_serial_mode)
		begin
			// wr_byte is read directly: stable while the flag crosses
			if (wr.wr_byte[BANK_SELECT_BIT])
				operate_config_reg <= {wr.wr_byte[RUN_BIT_POS], wr.wr_byte[PANEL_BIT_POS]};
			else
				standby_config_reg <= {wr.wr_byte[RUN_BIT_POS], wr.wr_byte[PANEL_BIT_POS]};
		end
	end

	// ----------------------------------------------------------------
	// dac counter / register
	// ----------------------------------------------------------------
	always_comb
	begin
		dac_next = dac_reg;
		if (i_serial_mode)
		begin
			if (wr_seen)
				dac_next = wr.wr_byte[4:0];
		end
		else if (!shutdown)
		begin
			if (raise_s && lower_s)
				dac_next = DAC_HALF_SCALE;
			else if ((raise_rise && sign_s) || (lower_rise && !sign_s))
			begin
				if (dac_reg != DAC_ZERO_CODE)
					dac_next = dac_reg - 5'h01;
			end
			else if ((lower_rise && sign_s) || (raise_rise && !sign_s))
			begin
				if (dac_reg != FULL_SCALE_CODE)
					dac_next = dac_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || supply_low_lockout_s)
			dac_reg <= DAC_HALF_SCALE;
		else
			dac_reg <= dac_next;
	end

	// ----------------------------------------------------------------
	// outputs and status
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			o_dac_code_bits         <= DAC_ZERO_CODE;
			o_panel_switch_drive_oe <= 1'b0;
			o_shutdown              <= 1'b0;
			status_reg              <= 8'h00;
		end
		else
		begin
			o_dac_code_bits         <= shutdown ? DAC_ZERO_CODE : dac_reg;
			o_panel_switch_drive_oe <= good_s && !shutdown && panel_on;
			o_shutdown              <= shutdown;
			status_reg              <= {good_s && !shutdown, 2'h0, dac_reg};
		end
	end

	// status is quasi-static; link samples it at address time
	assign wr.status_byte        = status_reg;
	assign o_panel_switch_drive  = 1'b0;
endmodule
`default_nettype wire

// ===== hdl/bdc_pkg.sv
/*
 * bdc_pkg: constants, reset values and field layout for the bias dac
 * counter control block.
 * Assumes: pins are asynchronous to i_sys_clk; the serial clock is a
 * separate domain.
 */
// Operation
// - Reset loads dac code to half-scale.
// - Positive polarity: raise edge decrements counter.
// - Positive polarity: lower edge increments counter.
// - Both inputs high, awake: force half-scale.
// - Counter saturates at zero and full-scale.
// - Negative polarity swaps counting direction.
// - Shutdown while power-down input low.
// - Shutdown ignores raise and lower edges.
// - Shutdown floats panel switch, dac zero.
// - Supply-good low floats panel switch.
// - Supply lockout resets counter to half-scale.
// - Serial target answers only address 0101100.
// - Bit7 selects bank; 6:5 config; 4:0 dac.
// - Config holds run bit and panel bit.
// - Standby select picks active config register.
// - Every written byte updates dac register.
// - Dac kept through shutdown and bank changes.
// - Active run bit zero means shutdown.
// - Serial writes still accepted during shutdown.
// - Read-byte returns a status byte.
// - Status: bit7 good-and-awake, 6:5 zero, dac.
// - Serial variant: panel bit gates panel switch.
package bdc_pkg;
	localparam logic [4:0] DAC_HALF_SCALE   = 5'h10;
	localparam logic [4:0] DAC_ZERO_CODE    = 5'h00;
	localparam logic [4:0] FULL_SCALE_CODE  = 5'h1F;
	localparam logic [1:0] STANDBY_RESET    = 2'h0;
	localparam logic [1:0] OPERATE_RESET    = 2'h3;
	localparam logic [6:0] TARGET_ADDRESS   = 7'h2C;
	localparam int         BANK_SELECT_BIT  = 7;
	localparam int         RUN_BIT_POS      = 6;
	localparam int         PANEL_BIT_POS    = 5;
	localparam int         STATUS_GOOD_POS  = 7;
	localparam int         SYNC_STAGES      = 2;

	typedef enum {
		BDC_IDLE,
		BDC_ADDR,
		BDC_ADDR_ACK,
		BDC_WDATA,
		BDC_WDATA_ACK,
		BDC_RDATA,
		BDC_RDATA_ACK,
		BDC_SKIP
	} bdc_link_state_e;
endpackage

// ===== hdl/bdc_wr_if.sv
/*
 * bdc_wr_if: carries written bytes from the serial domain into the
 * system domain and the status byte back.
 * Assumes: producer is the serial clock domain, consumer the system one.
 */
`timescale 1ns/1ns
`default_nettype none
interface bdc_wr_if;
	logic       wr_toggle;
	logic [7:0] wr_byte;
	logic [7:0] status_byte;
	modport link (output wr_toggle, output wr_byte, input status_byte);
	modport core (input wr_toggle, input wr_byte, output status_byte);
endinterface
`default_nettype wire

// ===== hdl/bdc_sync.sv
/*
 * bdc_sync: two flip-flop level synchroniser, one per bit.
 * Assumes: input is asynchronous to the destination clock.
 */
`timescale 1ns/1ns
`default_nettype none
module bdc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	import bdc_pkg::*;
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_reg <= '0;
			o_sync   <= '0;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/bdc_serial_target.sv
/*
 * bdc_serial_target: serial-bus target on the link clock. Takes
 * single-byte writes and answers read-byte with the status byte.
 * Assumes: sda input is sampled on scl rising edges; a frame begins with
 * a link reset, which the top derives from the start pin.
 */
`timescale 1ns/1ns
`default_nettype none
module bdc_serial_target (
	// link
	input  wire logic i_scl,
	input  wire logic i_rst_link,
	input  wire logic i_sda,
	output logic      o_sda_oe,
	// crossing
	bdc_wr_if.link    wr
);
	import bdc_pkg::*;
	bdc_link_state_e state_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic       rd_reg;
	logic [7:0] tx_reg;
	logic       ack_low_reg;

	// ----------------------------------------------------------------
	// byte engine, sampled on scl rise; start restarts address phase
	// ----------------------------------------------------------------
	always_ff @(posedge i_scl)
	begin
		if (i_rst_link)
		begin
			state_reg    <= BDC_ADDR;
			shift_reg    <= 8'h00;
			bit_cnt_reg  <= 4'h0;
			rd_reg       <= 1'b0;
			tx_reg       <= 8'h00;
			wr.wr_toggle <= 1'b0;
			wr.wr_byte   <= 8'h00;
		end
		else
		begin
			case (state_reg)
				BDC_ADDR, BDC_WDATA:
				begin
					shift_reg   <= {shift_reg[6:0], i_sda};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == 4'h7)
					begin
						bit_cnt_reg <= 4'h0;
						if (state_reg == BDC_ADDR)
						begin
							if (shift_reg[6:0] == TARGET_ADDRESS)
							begin
								rd_reg    <= i_sda;
								tx_reg    <= wr.status_byte;
								state_reg <= BDC_ADDR_ACK;
							end
							else
								state_reg <= BDC_SKIP;
						end
						else
						begin
							wr.wr_byte   <= {shift_reg[6:0], i_sda};
							// flag, not toggle: the next start clears it, so only its rise counts
							wr.wr_toggle <= 1'b1;
							state_reg    <= BDC_WDATA_ACK;
						end
					end
				end
				BDC_ADDR_ACK:
					state_reg <= rd_reg ? BDC_RDATA : BDC_WDATA;
				BDC_WDATA_ACK:
					state_reg <= BDC_SKIP;
				BDC_RDATA:
				begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == 4'h7)
					begin
						bit_cnt_reg <= 4'h0;
						state_reg   <= BDC_RDATA_ACK;
					end
					else
						tx_reg <= {tx_reg[6:0], 1'b0};
				end
				BDC_RDATA_ACK:
					state_reg <= BDC_SKIP;
				BDC_SKIP:
					state_reg <= BDC_SKIP;
				default:
					state_reg <= BDC_SKIP;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sda drive changes on scl fall so data is stable over the high
	// ----------------------------------------------------------------
	always_ff @(negedge i_scl)
	begin
		if (i_rst_link)
			ack_low_reg <= 1'b0;
		else
			case (state_reg)
				BDC_ADDR_ACK, BDC_WDATA_ACK:
					ack_low_reg <= 1'b1;
				BDC_RDATA:
					ack_low_reg <= ~tx_reg[7];
				default:
					ack_low_reg <= 1'b0;
			endcase
	end

	assign o_sda_oe = ack_low_reg;
endmodule
`default_nettype wire

// ===== testbench/bdc_top_properties.sv
/* bdc_top_properties: port-level assertions for bdc_top.
 * Assumes: bound to bdc_top; pin edges are at least 3 cycles apart. */
`timescale 1ns/1ns
`default_nettype none
module bdc_top_properties
	import bdc_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_rst,
	input wire logic       i_supply_low_lockout,
	input wire logic       i_serial_mode,
	input wire logic       i_raise_magnitude_in,
	input wire logic       i_lower_magnitude_in,
	input wire logic       i_power_down_n,
	input wire logic       i_output_sign_select,
	input wire logic       i_supply_good_sense,
	input wire logic       o_sda_oe,
	input wire logic       o_panel_switch_drive_oe,
	input wire logic [4:0] o_dac_code_bits,
	input wire logic       o_shutdown
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// ----
	// counter
	// ----
	chk_raise_step_down:
	assert property (!i_serial_mode && i_power_down_n && i_output_sign_select
		&& $rose(i_raise_magnitude_in) && !i_lower_magnitude_in && o_dac_code_bits != 5'h00
		|-> ##[2:5] o_dac_code_bits == $past(o_dac_code_bits) - 5'h01)
		else $error("raise edge gave no single step down");
	chk_sign_swap:
	assert property (!i_serial_mode && i_power_down_n && !i_output_sign_select
		&& $rose(i_raise_magnitude_in) && !i_lower_magnitude_in && o_dac_code_bits != 5'h1F
		|-> ##[2:5] o_dac_code_bits == $past(o_dac_code_bits) + 5'h01)
		else $error("negative sign raise edge gave no step up");
	chk_both_high_half:
	assert property ((!i_serial_mode && i_power_down_n && i_raise_magnitude_in
		&& i_lower_magnitude_in) [*6] |-> o_dac_code_bits == DAC_HALF_SCALE)
		else $error("both inputs high did not force half scale");
	chk_lockout_half:
	assert property (i_supply_low_lockout [*5] |-> o_dac_code_bits == DAC_HALF_SCALE || o_shutdown)
		else $error("lockout did not reload half scale");
	// ----
	// shutdown and panel
	// ----
	chk_pin_power_down:
	assert property ((!i_serial_mode && !i_power_down_n) [*5] |-> o_shutdown)
		else $error("power down input low but not shut down");
	chk_dac_zero_off:
	assert property (o_shutdown [*2] |-> o_dac_code_bits == DAC_ZERO_CODE)
		else $error("dac output not zero in shutdown");
	chk_panel_float_off:
	assert property (o_shutdown && $past(o_shutdown) |-> !o_panel_switch_drive_oe)
		else $error("panel switch driven in shutdown");
	chk_good_low_float:
	assert property (!i_supply_good_sense [*5] |-> !o_panel_switch_drive_oe)
		else $error("panel switch driven with supply good low");
	cov_floor: cover property (!i_serial_mode && o_dac_code_bits == 5'h00
		&& $rose(i_raise_magnitude_in));
	cov_off: cover property ($rose(o_shutdown));
	cov_ack: cover property ($rose(o_sda_oe));
endmodule
`default_nettype wire

// ===== testbench/bdc_host_model.sv
/* bdc_host_model: serial host, one byte per frame after a start pulse.
 * Assumes: the bench makes the open-drain line with a pull-up. */
`timescale 1ns/1ns
`default_nettype none
module bdc_host_model (
	// link
	output logic      o_scl,
	output logic      o_start,
	output logic      o_sda_low,
	input  wire logic i_sda
);
	initial
	begin
		o_scl = 1'b1;
		o_start = 1'b0;
		o_sda_low = 1'b0;
	end
	// data moves mid low phase, read back mid high phase
	task automatic bit9(input logic b, output logic s);
		o_scl = 1'b0;
		#20;
		o_sda_low = !b;
		#20;
		o_scl = 1'b1;
		#20;
		s = i_sda;
		#20;
	endtask
	task automatic run(input int n);
		logic s;
		repeat (n) bit9(1'b1, s);
	endtask
	// clock stands high between frames
	task automatic frame(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ack);
		logic s;
		o_start = 1'b1;
		run(2);
		o_start = 1'b0;
		// the target's reset trails the start pin by two link clocks
		run(2);
		for (int i = 7; i >= 0; i--) bit9(a[i], s);
		bit9(1'b1, s);
		ack = !s;
		for (int i = 7; i >= 0; i--) bit9(a[0] | d[i], q[i]);
		bit9(1'b1, s);
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_bias_dac_counter_control.sv
/* tb_bias_dac_counter_control: bench for bdc_top against a reference model.
 * Assumes: bdc_pkg, bdc_top, host model and checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
bind bdc_top bdc_top_properties chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_supply_low_lockout(i_supply_low_lockout), .i_serial_mode(i_serial_mode),
	.i_raise_magnitude_in(i_raise_magnitude_in), .i_lower_magnitude_in(i_lower_magnitude_in),
	.i_power_down_n(i_power_down_n), .i_output_sign_select(i_output_sign_select),
	.i_supply_good_sense(i_supply_good_sense), .o_sda_oe(o_sda_oe),
	.o_panel_switch_drive_oe(o_panel_switch_drive_oe),
	.o_dac_code_bits(o_dac_code_bits), .o_shutdown(o_shutdown));
module tb_bias_dac_counter_control;
	import bdc_pkg::*;
	logic       clk, rst, lock, smode, rais, lowr, pdn, sgn, good, sbn;
	logic       scl, start, hlow, oe, poe, sd, sdv, psv;
	logic [4:0] dac;
	wire        sda = !(hlow | oe);
	int         failures, n_tests, m_dac, sb, op, seed;
	bdc_host_model host (.o_scl(scl), .o_start(start), .o_sda_low(hlow), .i_sda(sda));
	bdc_top dut (.i_sys_clk(clk), .i_rst(rst), .i_supply_low_lockout(lock),
		.i_serial_mode(smode), .i_raise_magnitude_in(rais), .i_lower_magnitude_in(lowr),
		.i_power_down_n(pdn), .i_output_sign_select(sgn), .i_supply_good_sense(good),
		.i_standby_select_n(sbn), .i_scl(scl), .i_link_start(start), .i_sda(sda),
		.o_sda(sdv), .o_sda_oe(oe), .o_panel_switch_drive(psv),
		.o_panel_switch_drive_oe(poe), .o_dac_code_bits(dac), .o_shutdown(sd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int act();
		return sbn ? op : sb;
	endfunction
	function automatic int off();
		return smode ? (act() < 2) : !pdn;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string n, input int e, input logic [7:0] g);
		n_tests++;
		if (g !== 8'(e))
		begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic check_all();
		#1;
		chk("shutdown", off(), {7'h00, sd});
		chk("dac", off() ? 0 : m_dac, {3'h0, dac});
		chk("panel", good && !off() && (!smode || act() % 2), {7'h00, poe});
		chk("drive", 0, {6'h00, sdv, psv});
	endtask
	task automatic pulse(input logic r, input logic s);
		cyc(1);
		sgn <= s;
		cyc(4);
		rais <= r;
		lowr <= !r;
		cyc(3);
		rais <= 1'b0;
		lowr <= 1'b0;
		cyc(6);
		if (pdn)
			m_dac = (r == s) ? (m_dac > 0 ? m_dac - 1 : 0) : (m_dac < 31 ? m_dac + 1 : 31);
		check_all();
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       ack;
		host.frame({a, 1'b0}, d, q, ack);
		chk("ack", a == TARGET_ADDRESS, {7'h00, ack});
		if (a == TARGET_ADDRESS)
		begin
			m_dac = d[4:0];
			if (d[7])
				op = d[6:5];
			else
				sb = d[6:5];
		end
		cyc(10);
		check_all();
		host.frame({TARGET_ADDRESS, 1'b1}, 8'hFF, q, ack);
		chk("status", (good && !off()) * 128 + m_dac, q);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#900000;
		failures++;
		print_verdict();
	end
	initial
	begin
		{rst, smode, lock, rais, lowr} = 5'h10;
		{pdn, sgn, good, sbn} = 4'hF;
		{failures, n_tests, seed, m_dac, sb, op} = {32'd0, 32'd0, 32'd13170, 32'd16, 32'd0, 32'd3};
		cyc(4);
		rst <= 1'b0;
		cyc(6);
		check_all();
		for (int i = 0; i < 80; i++)
			pulse(i < 20 ? 1'b0 : i < 60 ? 1'b1 : 1'(rnd()),
				i < 60 ? 1'b1 : 1'(rnd()));
		rais <= 1'b1;
		lowr <= 1'b1;
		cyc(8);
		m_dac = 16;
		check_all();
		rais <= 1'b0;
		lowr <= 1'b0;
		pulse(1'b1, 1'b1);
		pdn <= 1'b0;
		cyc(6);
		check_all();
		pulse(1'b0, 1'b1);
		pdn <= 1'b1;
		good <= 1'b0;
		cyc(6);
		check_all();
		good <= 1'b1;
		lock <= 1'b1;
		cyc(6);
		lock <= 1'b0;
		cyc(6);
		{m_dac, sb, op} = {32'd16, 32'd0, 32'd3};
		check_all();
		rst <= 1'b1;
		smode <= 1'b1;
		cyc(4);
		rst <= 1'b0;
		host.run(3);
		check_all();
		wr(7'h2D, 8'h85);
		for (int i = 0; i < 16; i++)
		begin
			cyc(1);
			sbn <= 1'(rnd());
			good <= 1'(rnd());
			wr(TARGET_ADDRESS, {3'(i), 5'(rnd())});
			cyc(1);
			sbn <= !sbn;
			cyc(6);
			check_all();
		end
		print_verdict();
	end
endmodule
`default_nettype wire
